// ===== shared/ict_consts.vh
/*
 instruction cycle timing constants: class codes, size codes, addressing
 form codes and base figures for the timing lookup.
 assumes the decoder presents these encodings on the request port.
*/
`ifndef ICT_CONSTS_VH
`define ICT_CONSTS_VH

// instruction classes
`define ICT_CLS_SHIFT_REG 4'h0
`define ICT_CLS_SHIFT_MEM 4'h1
`define ICT_CLS_BIT_DYN 4'h2
`define ICT_CLS_BIT_STAT 4'h3
`define ICT_CLS_BRANCH 4'h4
`define ICT_CLS_DEC_BRANCH 4'h5
`define ICT_CLS_BOUNDS_TRAP 4'h6
`define ICT_CLS_OVF_TRAP 4'h7
`define ICT_CLS_BLOCK_REGISTER_MOVE_M2R 4'h8
`define ICT_CLS_BLOCK_REGISTER_MOVE_R2M 4'h9
`define ICT_CLS_EA_ONLY 4'hA

// sizes
`define ICT_SZ_BYTE 2'h0
`define ICT_SZ_WORD 2'h1
`define ICT_SZ_LONG 2'h2

// addressing forms
`define ICT_EA_DREG 4'h0
`define ICT_EA_AREG 4'h1
`define ICT_EA_IND 4'h2
`define ICT_EA_POSTINC 4'h3
`define ICT_EA_PREDEC 4'h4
`define ICT_EA_DISP 4'h5
`define ICT_EA_INDEX 4'h6
`define ICT_EA_ABS_W 4'h7
`define ICT_EA_ABS_L 4'h8
`define ICT_EA_PC_DISP 4'h9
`define ICT_EA_PC_INDEX 4'hA
`define ICT_EA_IMM 4'hB

// bit manipulation operation in sub-op
`define ICT_BIT_TOGGLE 2'h0
`define ICT_BIT_CLEAR 2'h1
`define ICT_BIT_SET 2'h2
`define ICT_BIT_TEST 2'h3

// shift/rotate base figures
`define ICT_SHIFT_BW_BASE 16'h0006
`define ICT_SHIFT_L_BASE 16'h0008
`define ICT_SHIFT_MEM_BASE 16'h0008

// conditional branch figures
`define ICT_BR_TAKEN 16'h000A
`define ICT_BR_NT_BYTE 16'h0008
`define ICT_BR_NT_WORD 16'h000C

// block register move bases
`define ICT_BLOCK_REGISTER_MOVE_M2R_BASE 16'h000C
`define ICT_BLOCK_REGISTER_MOVE_R2M_BASE 16'h0008

`endif

// ===== rtl/ict_timing.v
/*
 instruction cycle timing lookup: returns total clocks, bus reads and
 bus writes for one decoded instruction.
 assumes the decoder holds request fields valid with req_valid for one
 cycle, all on mclk; no handshake back is needed.
*/
// Overview of operation
// - register shift: 6/8 plus twice count
// - memory shift: 8 clocks, one read/write
// - block move scales with register count
// - index width never changes timing
// - address surcharge never has writes
// - move figures already include fetch
// - standard class covers op, store, prefetch
// - immediate class also covers extension fetch
// - flagged entries add surcharge clocks/reads
// - branch 10 taken, 8/12 not taken
// - starred entries are worst-case bounds
`timescale 1ns/1ps
`include "ict_consts.vh"

module ict_timing (
  // clock and reset
  input wire mclk,
  input wire rst,
  // request from decoder
  input wire req_valid,
  input wire [3:0] req_class,
  input wire [1:0] req_size,
  input wire [3:0] req_ea,
  input wire [1:0] req_subop,
  input wire req_taken,
  input wire [5:0] req_count,
  // answer to sequencer
  output reg res_valid,
  output reg [15:0] res_clocks,
  output reg [7:0] res_reads,
  output reg [7:0] res_writes,
  output reg res_max,
  output reg res_illegal
);

  // effective address surcharge: {clocks, reads}, never any write
  function [15:0] ea_cost;
    input [3:0] ea;
    input is_long;
    begin
      case (ea)
        `ICT_EA_IND: ea_cost = is_long ? 16'h0802 : 16'h0401;
        `ICT_EA_POSTINC: ea_cost = is_long ? 16'h0802 : 16'h0401;
        `ICT_EA_PREDEC: ea_cost = is_long ? 16'h0A02 : 16'h0601;
        `ICT_EA_DISP: ea_cost = is_long ? 16'h0C03 : 16'h0802;
        // index register width is not an input here
        `ICT_EA_INDEX: ea_cost = is_long ? 16'h0E03 : 16'h0A02;
        `ICT_EA_ABS_W: ea_cost = is_long ? 16'h0C03 : 16'h0802;
        `ICT_EA_ABS_L: ea_cost = is_long ? 16'h1004 : 16'h0C03;
        `ICT_EA_PC_DISP: ea_cost = is_long ? 16'h0C03 : 16'h0802;
        `ICT_EA_PC_INDEX: ea_cost = is_long ? 16'h0E03 : 16'h0A02;
        `ICT_EA_IMM: ea_cost = is_long ? 16'h0802 : 16'h0401;
        default: ea_cost = 16'h0000;
      endcase
    end
  endfunction

  // block move address-form surcharge over the base, in clocks and reads
  function [15:0] block_register_move_cost;
    input [3:0] ea;
    begin
      case (ea)
        `ICT_EA_DISP: block_register_move_cost = 16'h0401;
        `ICT_EA_INDEX: block_register_move_cost = 16'h0601;
        `ICT_EA_ABS_W: block_register_move_cost = 16'h0401;
        `ICT_EA_ABS_L: block_register_move_cost = 16'h0802;
        `ICT_EA_PC_DISP: block_register_move_cost = 16'h0401;
        `ICT_EA_PC_INDEX: block_register_move_cost = 16'h0601;
        default: block_register_move_cost = 16'h0000;
      endcase
    end
  endfunction

  wire is_long = (req_size == `ICT_SZ_LONG);
  wire [15:0] ea_pair = ea_cost(req_ea, is_long);
  wire [15:0] ea_clk = {8'h00, ea_pair[15:8]};
  wire [7:0] ea_rd = ea_pair[7:0];
  wire [15:0] mv_pair = block_register_move_cost(req_ea);
  wire [15:0] mv_clk = {8'h00, mv_pair[15:8]};
  wire [7:0] mv_rd = mv_pair[7:0];
  wire [15:0] cnt16 = {10'h000, req_count};
  wire [7:0] cnt8 = {2'b00, req_count};
  wire ea_is_reg = (req_ea == `ICT_EA_DREG) || (req_ea == `ICT_EA_AREG);

  reg [15:0] clocks_next;
  reg [7:0] reads_next;
  reg [7:0] writes_next;
  reg max_next;
  reg illegal_next;
  reg add_ea;

  always @* begin
    clocks_next = 16'h0000;
    reads_next = 8'h00;
    writes_next = 8'h00;
    max_next = 1'b0;
    illegal_next = 1'b0;
    add_ea = 1'b0;
    case (req_class)
      `ICT_CLS_SHIFT_REG: begin
        clocks_next = (is_long ? `ICT_SHIFT_L_BASE : `ICT_SHIFT_BW_BASE)
          + {cnt16[14:0], 1'b0};
        reads_next = 8'h01;
      end
      `ICT_CLS_SHIFT_MEM: begin
        if (is_long) begin
          illegal_next = 1'b1;
        end else begin
          clocks_next = `ICT_SHIFT_MEM_BASE;
          reads_next = 8'h01;
          writes_next = 8'h01;
          add_ea = 1'b1;
        end
      end
      `ICT_CLS_BIT_DYN, `ICT_CLS_BIT_STAT: begin
        if (ea_is_reg) begin
          reads_next = (req_class == `ICT_CLS_BIT_STAT) ? 8'h02 : 8'h01;
          case (req_subop)
            `ICT_BIT_CLEAR: clocks_next = 16'h000A;
            `ICT_BIT_TEST: clocks_next = 16'h0006;
            default: clocks_next = 16'h0008;
          endcase
          if (req_class == `ICT_CLS_BIT_STAT)
            clocks_next = clocks_next + 16'h0004;
          max_next = (req_subop != `ICT_BIT_TEST);
        end else begin
          add_ea = 1'b1;
          reads_next = (req_class == `ICT_CLS_BIT_STAT) ? 8'h02 : 8'h01;
          writes_next = (req_subop == `ICT_BIT_TEST) ? 8'h00 : 8'h01;
          clocks_next = (req_subop == `ICT_BIT_TEST) ? 16'h0004 : 16'h0008;
          if (req_class == `ICT_CLS_BIT_STAT)
            clocks_next = clocks_next + 16'h0004;
        end
      end
      `ICT_CLS_BRANCH: begin
        // taken vs not taken by displacement size
        if (req_taken) begin
          clocks_next = `ICT_BR_TAKEN;
          reads_next = 8'h02;
        end else if (req_size == `ICT_SZ_BYTE) begin
          clocks_next = `ICT_BR_NT_BYTE;
          reads_next = 8'h01;
        end else begin
          clocks_next = `ICT_BR_NT_WORD;
          reads_next = 8'h02;
        end
      end
      `ICT_CLS_DEC_BRANCH: begin
        // subop[0] = condition true; taken = counter not expired
        if (req_subop[0]) begin
          clocks_next = 16'h000C;
          reads_next = 8'h02;
        end else if (req_taken) begin
          clocks_next = 16'h000A;
          reads_next = 8'h02;
        end else begin
          clocks_next = 16'h000E;
          reads_next = 8'h03;
        end
      end
      `ICT_CLS_BOUNDS_TRAP: begin
        add_ea = 1'b1;
        if (req_taken) begin
          clocks_next = 16'h0028;
          reads_next = 8'h05;
          writes_next = 8'h03;
          max_next = 1'b1;
        end else begin
          clocks_next = 16'h0008;
          reads_next = 8'h01;
        end
      end
      `ICT_CLS_OVF_TRAP: begin
        clocks_next = req_taken ? 16'h0022 : 16'h0004;
        reads_next = req_taken ? 8'h05 : 8'h01;
        writes_next = req_taken ? 8'h03 : 8'h00;
      end
      `ICT_CLS_BLOCK_REGISTER_MOVE_M2R: begin
        // memory to register, index width ignored
        clocks_next = `ICT_BLOCK_REGISTER_MOVE_M2R_BASE + mv_clk
          + (is_long ? {cnt16[12:0], 3'b000} : {cnt16[13:0], 2'b00});
        reads_next = 8'h03 + mv_rd + (is_long ? {cnt8[6:0], 1'b0} : cnt8);
        illegal_next = (req_ea == `ICT_EA_PREDEC) || ea_is_reg;
      end
      `ICT_CLS_BLOCK_REGISTER_MOVE_R2M: begin
        clocks_next = `ICT_BLOCK_REGISTER_MOVE_R2M_BASE + mv_clk
          + (is_long ? cnt16 * 16'd10 : cnt16 * 16'd5);
        reads_next = 8'h02 + mv_rd;
        writes_next = is_long ? {cnt8[6:0], 1'b0} : cnt8;
        illegal_next = (req_ea == `ICT_EA_POSTINC)
          || (req_ea == `ICT_EA_PC_DISP) || (req_ea == `ICT_EA_PC_INDEX)
          || ea_is_reg;
      end
      `ICT_CLS_EA_ONLY: begin
        // base figures from decoder include fetches
        add_ea = 1'b1;
      end
      default: illegal_next = 1'b1;
    endcase
    // add surcharge clocks and reads; writes unchanged
    if (add_ea && !illegal_next) begin
      clocks_next = clocks_next + ea_clk;
      reads_next = reads_next + ea_rd;
    end
    if (illegal_next) begin
      clocks_next = 16'h0000;
      reads_next = 8'h00;
      writes_next = 8'h00;
      max_next = 1'b0;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      res_valid <= 1'b0;
      res_clocks <= 16'h0000;
      res_reads <= 8'h00;
      res_writes <= 8'h00;
      res_max <= 1'b0;
      res_illegal <= 1'b0;
    end else begin
      res_valid <= req_valid;
      if (req_valid) begin
        res_clocks <= clocks_next;
        res_reads <= reads_next;
        res_writes <= writes_next;
        res_max <= max_next;
        res_illegal <= illegal_next;
      end
    end
  end

endmodule

// ===== sim/ict_timing_chk.sv
/*
 checker for the timing lookup, seeing only the top ports.
 assumes ict_consts.vh is on the include path.
*/
`timescale 1ns/1ps
`include "ict_consts.vh"
module ict_timing_chk (
  // clock and reset
  input wire mclk,
  input wire rst,
  // request
  input wire req_valid,
  input wire [3:0] req_class,
  input wire [1:0] req_size,
  input wire [3:0] req_ea,
  input wire [1:0] req_subop,
  input wire req_taken,
  input wire [5:0] req_count,
  // answer
  input wire res_valid,
  input wire [15:0] res_clocks,
  input wire [7:0] res_reads,
  input wire [7:0] res_writes,
  input wire res_max,
  input wire res_illegal
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence shift_req(bit lng);
    req_valid && req_class == `ICT_CLS_SHIFT_REG &&
      (req_size == `ICT_SZ_LONG) == lng;
  endsequence
  sequence br_req(bit tk);
    req_valid && req_class == `ICT_CLS_BRANCH && req_taken == tk;
  endsequence
  answer_pulse_a: assert property (req_valid |=> res_valid)
    else $error("missing answer");
  hold_result_a: assert property (!req_valid |=> !res_valid &&
    $stable(res_clocks) && $stable(res_reads)) else $error("not held");
  shift_short_a: assert property (shift_req(1'b0) |=>
    res_clocks == 16'h0006 + 2 * $past(req_count) && res_reads == 8'h01
    && res_writes == 8'h00) else $error("short shift");
  shift_long_a: assert property (shift_req(1'b1) |=>
    res_clocks == 16'h0008 + 2 * $past(req_count)) else $error("long shift");
  mem_long_a: assert property (req_valid && req_size == `ICT_SZ_LONG &&
    req_class == `ICT_CLS_SHIFT_MEM |=> res_illegal && res_clocks == 0)
    else $error("long memory shift");
  br_taken_a: assert property (br_req(1'b1) |=>
    res_clocks == 16'h000A && res_reads == 8'h02) else $error("taken");
  br_fall_a: assert property (br_req(1'b0) |=> res_clocks ==
    ($past(req_size) == `ICT_SZ_BYTE ? 16'h0008 : 16'h000C))
    else $error("not taken");
  ea_nowrite_a: assert property (req_valid &&
    req_class == `ICT_CLS_EA_ONLY |=> res_writes == 0) else $error("write");
endmodule
bind ict_timing ict_timing_chk i_ict_timing_chk (.*);

// ===== sim/ict_seq_model.sv
/*
 sequencer side model: counts answers of the timing lookup.
 assumes answers come as one-cycle res_valid pulses on mclk.
*/
`timescale 1ns/1ps
module ict_seq_model (
  // clock and reset
  input wire mclk,
  input wire rst,
  // answer
  input wire res_valid,
  output reg [15:0] rsp_count
);
  always @(posedge mclk) begin
    if (rst) begin
      rsp_count <= 16'h0000;
    end else if (res_valid) begin
      rsp_count <= rsp_count + 16'h0001;
    end
  end
endmodule

// ===== sim/ict_timing_tb.sv
/*
 self-checking bench for the timing lookup.
 assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ps
module ict_timing_tb;
  reg mclk, rst, req_valid, req_taken;
  reg [3:0] req_class, req_ea;
  reg [1:0] req_size, req_subop;
  reg [5:0] req_count;
  wire res_valid, res_max, res_illegal;
  wire [15:0] res_clocks, rsp_count;
  wire [7:0] res_reads, res_writes;
  wire [34:0] res_word = {res_valid, res_clocks, res_reads, res_writes,
    res_max, res_illegal};
  integer num_errors = 0;
  integer check_count = 0;
  integer sent = 0;
  integer n, s;
  ict_timing i_ict_timing (.*);
  ict_seq_model i_ict_seq_model (.mclk(mclk), .rst(rst),
    .res_valid(res_valid), .rsp_count(rsp_count));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task chk(input [34:0] got, input [34:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task put(input [3:0] c, input [1:0] z, input [3:0] e, input [1:0] o,
    input t, input [5:0] k);
    begin
      @(posedge mclk);
      req_valid <= 1'b1;
      req_class <= c;
      req_size <= z;
      req_ea <= e;
      req_subop <= o;
      req_taken <= t;
      req_count <= k;
      sent = sent + 1;
    end
  endtask
  task see(input [15:0] k, input [7:0] r, input [7:0] w, input [1:0] f);
    begin
      @(posedge mclk);
      req_valid <= 1'b0;
      #1 chk(res_word, {1'b1, k, r, w, f});
    end
  endtask
  task t_shift;
    begin
      for (n = 0; n < 64; n = n + 63)
        for (s = 0; s < 3; s = s + 1) begin
          put(4'h0, s[1:0], 4'h0, 2'h0, 1'b0, n[5:0]);
          see((s == 2 ? 16'h0008 : 16'h0006) + 2 * n, 8'h01, 8'h00,
            2'h0);
        end
      put(4'h1, 2'h1, 4'h2, 2'h0, 1'b0, 6'h00);
      see(16'h000C, 8'h02, 8'h01, 2'h0);
      put(4'h1, 2'h2, 4'h2, 2'h0, 1'b0, 6'h00);
      see(16'h0000, 8'h00, 8'h00, 2'h1);
    end
  endtask
  task t_branch;
    begin
      put(4'h4, 2'h0, 4'h0, 2'h0, 1'b1, 6'h00);
      put(4'h4, 2'h0, 4'h0, 2'h0, 1'b0, 6'h00);
      #1 chk(res_word, {1'b1, 16'h000A, 8'h02, 8'h00, 2'h0});
      put(4'h4, 2'h1, 4'h0, 2'h0, 1'b0, 6'h00);
      #1 chk(res_word, {1'b1, 16'h0008, 8'h01, 8'h00, 2'h0});
      see(16'h000C, 8'h02, 8'h00, 2'h0);
      // decrement branch: condition true, loop taken, counter expired
      put(4'h5, 2'h1, 4'h0, 2'h1, 1'b0, 6'h00);
      see(16'h000C, 8'h02, 8'h00, 2'h0);
      put(4'h5, 2'h1, 4'h0, 2'h0, 1'b1, 6'h00);
      see(16'h000A, 8'h02, 8'h00, 2'h0);
      put(4'h5, 2'h1, 4'h0, 2'h0, 1'b0, 6'h00);
      see(16'h000E, 8'h03, 8'h00, 2'h0);
      // traps: overflow taken and not, bounds check taken is a bound
      put(4'h7, 2'h1, 4'h0, 2'h0, 1'b1, 6'h00);
      see(16'h0022, 8'h05, 8'h03, 2'h0);
      put(4'h7, 2'h1, 4'h0, 2'h0, 1'b0, 6'h00);
      see(16'h0004, 8'h01, 8'h00, 2'h0);
      put(4'h6, 2'h1, 4'h0, 2'h0, 1'b1, 6'h00);
      see(16'h0028, 8'h05, 8'h03, 2'h2);
    end
  endtask
  task t_block_register_move;
    begin
      put(4'h8, 2'h1, 4'h2, 2'h0, 1'b0, 6'h03);
      see(16'h0018, 8'h06, 8'h00, 2'h0);
      put(4'h8, 2'h2, 4'h6, 2'h0, 1'b0, 6'h02);
      see(16'h0022, 8'h08, 8'h00, 2'h0);
      put(4'h9, 2'h1, 4'h4, 2'h0, 1'b0, 6'h04);
      see(16'h001C, 8'h02, 8'h04, 2'h0);
      put(4'h9, 2'h2, 4'h8, 2'h0, 1'b0, 6'h01);
      see(16'h001A, 8'h04, 8'h02, 2'h0);
      put(4'h9, 2'h1, 4'h3, 2'h0, 1'b0, 6'h02);
      see(16'h0000, 8'h00, 8'h00, 2'h1);
    end
  endtask
  task t_ea_bit;
    begin
      for (s = 6; s < 11; s = s + 4) begin
        put(4'hA, 2'h1, s[3:0], 2'h0, 1'b0, 6'h00);
        see(16'h000A, 8'h02, 8'h00, 2'h0);
        put(4'hA, 2'h2, s[3:0], 2'h0, 1'b0, 6'h00);
        see(16'h000E, 8'h03, 8'h00, 2'h0);
      end
      put(4'h2, 2'h2, 4'h0, 2'h1, 1'b0, 6'h00);
      see(16'h000A, 8'h01, 8'h00, 2'h2);
      put(4'h3, 2'h2, 4'h0, 2'h1, 1'b0, 6'h00);
      see(16'h000E, 8'h02, 8'h00, 2'h2);
      put(4'h2, 2'h2, 4'h0, 2'h3, 1'b0, 6'h00);
      see(16'h0006, 8'h01, 8'h00, 2'h0);
    end
  endtask
  task t_reset;
    begin
      @(posedge mclk);
      #1 chk({19'h0_0000, rsp_count}, sent);
      put(4'h4, 2'h0, 4'h0, 2'h0, 1'b1, 6'h00);
      @(posedge mclk);
      rst <= 1'b1;
      req_valid <= 1'b0;
      @(posedge mclk);
      rst <= 1'b0;
      #1 chk(res_word, 35'h0_0000_0000);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_taken = 1'b0;
    req_class = 4'h0;
    req_ea = 4'h0;
    req_size = 2'h0;
    req_subop = 2'h0;
    req_count = 6'h00;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_shift;
    $display("shift done");
    t_branch;
    $display("branch done");
    t_block_register_move;
    $display("block move done");
    t_ea_bit;
    $display("surcharge and bit done");
    t_reset;
    $display("reset done");
    close_out;
  end
endmodule
